// *** core/adc_conv_sequencer.sv ***
`timescale 1ns/1ns
`include "adc_conversion_control_regs.svh"
module adc_conv_sequencer #(
  parameter int DIV_W = 7,
  parameter int PHASE_W = 5
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  conv_if.seq bus
);
  adc_conversion_control_pkg::seq_state_t state_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [DIV_W-1:0] div_mask;
  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] last_phase;
  logic tick;
  logic run_ok;
  logic done_reg;
  logic step_reg;

  // Divide by two to the power of the select code
  assign div_mask = DIV_W'((1 << bus.div_sel) - 1);
  assign tick = &(div_cnt_reg | ~div_mask);
  assign last_phase = PHASE_W'(`ADC_SAMPLE_TICKS + `ADC_CONVERT_TICKS - 5'h01);
  assign run_ok = bus.power && !bus.abort;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= adc_conversion_control_pkg::SEQ_IDLE;
      div_cnt_reg <= '0;
      phase_reg <= '0;
    end else if (i_clk_en) begin
      if (!run_ok) begin
        state_reg <= adc_conversion_control_pkg::SEQ_IDLE;
        div_cnt_reg <= '0;
        phase_reg <= '0;
      end else begin
        unique case (state_reg)
          adc_conversion_control_pkg::SEQ_IDLE: begin
            if (bus.go) begin
              state_reg <= adc_conversion_control_pkg::SEQ_SAMPLE;
              div_cnt_reg <= '0;
              phase_reg <= '0;
            end
          end
          adc_conversion_control_pkg::SEQ_SAMPLE,
          adc_conversion_control_pkg::SEQ_CONVERT: begin
            div_cnt_reg <= tick ? '0 : DIV_W'(div_cnt_reg + 1'b1);
            if (tick) begin
              phase_reg <= PHASE_W'(phase_reg + 1'b1);
              if (state_reg == adc_conversion_control_pkg::SEQ_SAMPLE &&
                  phase_reg == PHASE_W'(`ADC_SAMPLE_TICKS - 5'h01)) begin
                state_reg <= adc_conversion_control_pkg::SEQ_CONVERT;
              end
              if (state_reg == adc_conversion_control_pkg::SEQ_CONVERT && phase_reg == last_phase) begin
                state_reg <= adc_conversion_control_pkg::SEQ_IDLE;
              end
            end
          end
          default: begin
            state_reg <= adc_conversion_control_pkg::SEQ_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      done_reg <= 1'b0;
      step_reg <= 1'b0;
    end else if (i_clk_en) begin
      done_reg <= run_ok && tick && phase_reg == last_phase &&
                  state_reg == adc_conversion_control_pkg::SEQ_CONVERT;
      step_reg <= run_ok && tick && state_reg == adc_conversion_control_pkg::SEQ_CONVERT;
    end
  end

  assign bus.busy = state_reg != adc_conversion_control_pkg::SEQ_IDLE;
  assign bus.sampling = state_reg == adc_conversion_control_pkg::SEQ_SAMPLE;
  assign bus.done = done_reg;
  assign bus.step = step_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset || !i_clk_en);

  property p_sample_first;
    $rose(bus.busy) |-> bus.sampling;
  endproperty
  a_sample_first: assert property (p_sample_first) else $error("Conversion did not open with sampling");

  property p_done_idle;
    bus.done |-> !bus.busy && !$past(bus.sampling);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("Done pulse while still busy");

endmodule : adc_conv_sequencer

// *** core/adc_conversion_control.sv ***
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`include "adc_conversion_control_regs.svh"
// Operation
// - Analog-selected pin routes to converter, exclusively
// - Analog pin drops its pull-high resistor
// - Analog pin ignores port direction setting
// - Reference from pin, supply or bandgap
// - Four sample ticks then twelve convert ticks
// - Conversion runs on its own once started
// - Power enable low keeps converter unpowered
// - Source field picks external or internal signal
// - Format bit arranges result across bytes
// - Start high resets, start low begins
// - Busy high during conversion, result then valid
// - Result twelve bits, full scale FFF
// - Writing 20h powers and selects channel zero
// - Writing 01h makes channel zero pin analog
// - Divider code gives clock over two to code
// - Completion sets flag, enables gate interrupt
module adc_conversion_control #(
  parameter int PINS = 8,
  parameter int LEN_W = 12
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [11:0] i_core_result,
  input wire logic i_irq_ack,
  output logic [PINS-1:0] o_pin_analog,
  output logic [PINS-1:0] o_pin_pullup,
  output logic [PINS-1:0] o_pin_output_enable,
  output logic [PINS-1:0] o_channel_connect,
  output logic [2:0] o_internal_source,
  output logic o_internal_connect,
  output logic o_ref_from_pin,
  output logic o_ref_from_bandgap,
  output logic [2:0] o_ref_gain,
  output logic o_ref_output_enable,
  output logic o_converter_power,
  output logic o_converter_reset,
  output logic o_sampling,
  output logic o_conv_step,
  output logic o_conversion_done,
  output logic o_irq_request
);
  conv_if seq_bus ();

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [PINS-1:0] pin_sel_reg;
  logic [PINS-1:0] dir_reg;
  logic [PINS-1:0] pull_reg;
  logic gie_reg;
  logic cie_reg;
  logic flag_reg;
  logic go_reg;
  logic [11:0] result_reg;
  logic [2:0] div_at_go_reg;
  logic [LEN_W-1:0] busy_cycles_reg;

  logic req;
  logic accept;
  logic wr_en;
  logic [3:0] idx;
  logic [7:0] wbyte;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic [7:0] ctrl0_read;
  logic [31:0] rdata_next;
  logic start_bit;
  logic power_bit;
  logic [3:0] chan_sel;
  logic [2:0] src_sel;
  logic [3:0] ref_sel;
  logic ext_source;
  logic ref_pin_next;
  logic ref_bg_next;
  logic [PINS-1:0] pull_next;
  logic [PINS-1:0] oe_next;
  logic [PINS-1:0] connect_next;

  // Avalon slave: one wait cycle, then the access is taken
  assign req = i_avs_read || i_avs_write;
  assign accept = req && !wait_reg;
  assign wr_en = i_avs_write && !wait_reg && i_avs_byteenable[0];
  assign idx = i_avs_address[5:2];
  assign wbyte = i_avs_writedata[7:0];

  assign start_bit = ctrl0_reg[`ADC_CTRL0_START];
  assign power_bit = ctrl0_reg[`ADC_CTRL0_POWER];
  assign chan_sel = ctrl0_reg[`ADC_CTRL0_CHAN_MSB:`ADC_CTRL0_CHAN_LSB];
  assign src_sel = ctrl1_reg[`ADC_CTRL1_SRC_MSB:`ADC_CTRL1_SRC_LSB];
  assign ref_sel = ctrl2_reg[`ADC_CTRL2_REF_MSB:`ADC_CTRL2_REF_LSB];
  assign ext_source = src_sel == `ADC_SRC_EXTERNAL;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (accept) begin
        wait_reg <= 1'b1;
      end else if (req) begin
        wait_reg <= 1'b0;
        rdata_reg <= i_avs_read ? rdata_next : 32'h0000_0000;
      end
    end
  end

  // Result arrangement: format low is left-justified, high is right-justified
  always_comb begin
    if (ctrl0_reg[`ADC_CTRL0_FORMAT]) begin
      res_hi = {4'h0, result_reg[11:8]};
      res_lo = result_reg[7:0];
    end else begin
      res_hi = result_reg[11:4];
      res_lo = {result_reg[3:0], 4'h0};
    end
  end

  always_comb begin
    ctrl0_read = ctrl0_reg;
    ctrl0_read[`ADC_CTRL0_BUSY] = seq_bus.busy;
    rdata_next = 32'h0000_0000;
    case (idx)
      `ADC_IDX_CTRL0: rdata_next = 32'(ctrl0_read);
      `ADC_IDX_CTRL1: rdata_next = 32'(ctrl1_reg);
      `ADC_IDX_CTRL2: rdata_next = 32'(ctrl2_reg);
      `ADC_IDX_PIN_SEL: rdata_next = 32'(pin_sel_reg);
      `ADC_IDX_DIR: rdata_next = 32'(dir_reg);
      `ADC_IDX_PULL: rdata_next = 32'(pull_reg);
      `ADC_IDX_RES_HI: rdata_next = 32'(res_hi);
      `ADC_IDX_RES_LO: rdata_next = 32'(res_lo);
      `ADC_IDX_INTC: rdata_next = 32'({flag_reg, cie_reg, gie_reg});
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Converter control registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl0_reg <= `ADC_CTRL0_RST;
      ctrl1_reg <= `ADC_CTRL1_RST;
      ctrl2_reg <= `ADC_CTRL2_RST;
    end else if (i_clk_en && wr_en) begin
      if (idx == `ADC_IDX_CTRL0) begin
        ctrl0_reg <= wbyte & `ADC_CTRL0_WMASK;
      end
      if (idx == `ADC_IDX_CTRL1) begin
        ctrl1_reg <= wbyte & `ADC_CTRL1_WMASK;
      end
      if (idx == `ADC_IDX_CTRL2) begin
        ctrl2_reg <= wbyte & `ADC_CTRL2_WMASK;
      end
    end
  end

  // Port function, direction and pull-high registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_sel_reg <= PINS'(`ADC_PIN_SEL_RST);
      dir_reg <= PINS'(`ADC_DIR_RST);
      pull_reg <= PINS'(`ADC_PULL_RST);
    end else if (i_clk_en && wr_en) begin
      if (idx == `ADC_IDX_PIN_SEL) begin
        pin_sel_reg <= PINS'(wbyte);
      end
      if (idx == `ADC_IDX_DIR) begin
        dir_reg <= PINS'(wbyte);
      end
      if (idx == `ADC_IDX_PULL) begin
        pull_reg <= PINS'(wbyte);
      end
    end
  end

  // Start falling edge launches a conversion one cycle later, after the reset level is gone
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      go_reg <= 1'b0;
    end else if (i_clk_en) begin
      go_reg <= wr_en && idx == `ADC_IDX_CTRL0 && start_bit && !wbyte[`ADC_CTRL0_START];
    end
  end

  assign seq_bus.go = go_reg;
  assign seq_bus.abort = start_bit;
  assign seq_bus.power = power_bit;
  assign seq_bus.div_sel = ctrl1_reg[`ADC_CTRL1_DIV_MSB:`ADC_CTRL1_DIV_LSB];

  adc_conv_sequencer u_seq (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .bus(seq_bus.seq)
  );

  // Result held until the next completed conversion
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      result_reg <= 12'h000;
    end else if (i_clk_en && seq_bus.done) begin
      result_reg <= i_core_result;
    end
  end

  // Interrupt enables and request flag; completion wins over any clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      gie_reg <= 1'b0;
      cie_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_en && idx == `ADC_IDX_INTC) begin
        gie_reg <= wbyte[`ADC_INTC_GIE];
        cie_reg <= wbyte[`ADC_INTC_CIE];
      end
      if (seq_bus.done) begin
        flag_reg <= 1'b1;
      end else if (i_irq_ack) begin
        flag_reg <= 1'b0;
      end else if (wr_en && idx == `ADC_IDX_INTC) begin
        flag_reg <= wbyte[`ADC_INTC_FLAG];
      end
    end
  end

  // Pin function overrides
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    assign pull_next[i] = pull_reg[i] && !pin_sel_reg[i];
    assign oe_next[i] = !dir_reg[i] && !pin_sel_reg[i];
    assign connect_next[i] = power_bit && ext_source && pin_sel_reg[i] && chan_sel == 4'(i);
  end

  assign ref_pin_next = ref_sel >= `ADC_REF_PIN_LO && ref_sel <= `ADC_REF_PIN_HI;
  assign ref_bg_next = ref_sel >= `ADC_REF_BG_LO && ref_sel <= `ADC_REF_BG_HI;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pin_analog <= '0;
      o_pin_pullup <= '0;
      o_pin_output_enable <= '0;
      o_channel_connect <= '0;
      o_internal_source <= 3'h0;
      o_internal_connect <= 1'b0;
      o_ref_from_pin <= 1'b0;
      o_ref_from_bandgap <= 1'b0;
      o_ref_gain <= `ADC_GAIN_UNITY;
      o_ref_output_enable <= 1'b0;
    end else if (i_clk_en) begin
      o_pin_analog <= pin_sel_reg;
      o_pin_pullup <= pull_next;
      o_pin_output_enable <= oe_next;
      o_channel_connect <= connect_next;
      o_internal_source <= src_sel;
      o_internal_connect <= power_bit && !ext_source;
      o_ref_from_pin <= ref_pin_next && !ref_bg_next;
      o_ref_from_bandgap <= ref_bg_next;
      o_ref_gain <= (ref_pin_next || ref_bg_next) ? ref_sel[2:0] : `ADC_GAIN_UNITY;
      o_ref_output_enable <= power_bit && ctrl2_reg[`ADC_CTRL2_REF_OUT];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_converter_power <= 1'b0;
      o_converter_reset <= 1'b1;
      o_sampling <= 1'b0;
      o_conv_step <= 1'b0;
      o_conversion_done <= 1'b0;
      o_irq_request <= 1'b0;
    end else if (i_clk_en) begin
      o_converter_power <= power_bit;
      o_converter_reset <= start_bit || !power_bit;
      o_sampling <= seq_bus.sampling;
      o_conv_step <= seq_bus.step;
      o_conversion_done <= seq_bus.done;
      o_irq_request <= flag_reg && gie_reg && cie_reg;
    end
  end

  assign o_avs_waitrequest = wait_reg;
  assign o_avs_readdata = rdata_reg;

  // Helper: cycles spent busy in the current conversion
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_cycles_reg <= '0;
      div_at_go_reg <= 3'h0;
    end else if (i_clk_en) begin
      if (go_reg) begin
        busy_cycles_reg <= '0;
        div_at_go_reg <= seq_bus.div_sel;
      end else if (seq_bus.busy) begin
        busy_cycles_reg <= LEN_W'(busy_cycles_reg + 1'b1);
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset || !i_clk_en);

  property p_go_busy;
    go_reg && power_bit |=> seq_bus.busy;
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("Start release did not raise busy");

  property p_conv_len;
    seq_bus.done && seq_bus.div_sel == div_at_go_reg |->
      busy_cycles_reg == LEN_W'(`ADC_BASE_CYCLES << div_at_go_reg);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("Conversion length not sixteen ticks");

  property p_start_reset;
    start_bit |=> !seq_bus.busy;
  endproperty
  a_start_reset: assert property (p_start_reset) else $error("Start high did not reset converter");

  property p_power_off;
    !power_bit |=> !seq_bus.busy && !o_converter_power;
  endproperty
  a_power_off: assert property (p_power_off) else $error("Converter active while unpowered");

  property p_flag_set;
    seq_bus.done |=> flag_reg && result_reg == $past(i_core_result);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Completion missed flag or result");

  property p_result_hold;
    !seq_bus.done |=> $stable(result_reg);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("Result changed without completion");

  property p_flag_hold;
    flag_reg && !i_irq_ack && !(wr_en && idx == `ADC_IDX_INTC) |=> flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flag dropped without clear");

  property p_pullup_off;
    1'b1 |=> (o_pin_pullup & $past(pin_sel_reg)) == '0;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("Pull-high on analog pin");

  property p_dir_ignored;
    1'b1 |=> (o_pin_output_enable & $past(pin_sel_reg)) == '0;
  endproperty
  a_dir_ignored: assert property (p_dir_ignored) else $error("Analog pin driven as output");

  property p_irq_gate;
    1'b1 |=> o_irq_request == ($past(flag_reg) && $past(gie_reg) && $past(cie_reg));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("Interrupt request not gated by enables");

  property p_bus_answer;
    req && wait_reg |=> !wait_reg;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("Bus access not answered next cycle");

  c_done: cover property (seq_bus.done);
  c_abort: cover property (seq_bus.busy && start_bit);
  c_irq: cover property (o_irq_request);
  c_read_result: cover property (accept && i_avs_read && idx == `ADC_IDX_RES_LO);

endmodule : adc_conversion_control

// *** core/adc_conversion_control_pkg.sv ***
package adc_conversion_control_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SAMPLE = 2'b01,
    SEQ_CONVERT = 2'b11
  } seq_state_t;

endpackage : adc_conversion_control_pkg

// *** core/adc_conversion_control_regs.svh ***
`ifndef ADC_CONVERSION_CONTROL_REGS_SVH
`define ADC_CONVERSION_CONTROL_REGS_SVH

// Register word indices, byte address is four times the index
`define ADC_IDX_CTRL0 4'h0
`define ADC_IDX_CTRL1 4'h1
`define ADC_IDX_CTRL2 4'h2
`define ADC_IDX_PIN_SEL 4'h3
`define ADC_IDX_DIR 4'h4
`define ADC_IDX_PULL 4'h5
`define ADC_IDX_RES_HI 4'h6
`define ADC_IDX_RES_LO 4'h7
`define ADC_IDX_INTC 4'h8

// converter_control_zero fields
`define ADC_CTRL0_START 7
`define ADC_CTRL0_BUSY 6
`define ADC_CTRL0_POWER 5
`define ADC_CTRL0_FORMAT 4
`define ADC_CTRL0_CHAN_MSB 3
`define ADC_CTRL0_CHAN_LSB 0
`define ADC_CTRL0_WMASK 8'hBF
`define ADC_CTRL0_RST 8'h00

// converter_control_one fields
`define ADC_CTRL1_SRC_MSB 7
`define ADC_CTRL1_SRC_LSB 5
`define ADC_CTRL1_DIV_MSB 2
`define ADC_CTRL1_DIV_LSB 0
`define ADC_CTRL1_WMASK 8'hE7
`define ADC_CTRL1_RST 8'h00
`define ADC_SRC_EXTERNAL 3'h0

// converter_control_two fields
`define ADC_CTRL2_REF_OUT 4
`define ADC_CTRL2_REF_MSB 3
`define ADC_CTRL2_REF_LSB 0
`define ADC_CTRL2_WMASK 8'h1F
`define ADC_CTRL2_RST 8'h00
`define ADC_REF_PIN_LO 4'h1
`define ADC_REF_PIN_HI 4'h4
`define ADC_REF_BG_LO 4'hA
`define ADC_REF_BG_HI 4'hC
`define ADC_GAIN_UNITY 3'h1

// Port registers
`define ADC_PIN_SEL_RST 8'h00
`define ADC_DIR_RST 8'hFF
`define ADC_PULL_RST 8'h00

// Interrupt control fields
`define ADC_INTC_GIE 0
`define ADC_INTC_CIE 1
`define ADC_INTC_FLAG 2

// Conversion timing in converter clock ticks
`define ADC_SAMPLE_TICKS 5'h04
`define ADC_CONVERT_TICKS 5'h0C
`define ADC_BASE_CYCLES 12'h010

`endif

// *** core/conv_if.sv ***
`timescale 1ns/1ns
interface conv_if;
  logic go;
  logic abort;
  logic power;
  logic [2:0] div_sel;
  logic busy;
  logic sampling;
  logic step;
  logic done;

  modport ctrl (output go, output abort, output power, output div_sel,
                input busy, input sampling, input step, input done);
  modport seq (input go, input abort, input power, input div_sel,
               output busy, output sampling, output step, output done);
endinterface : conv_if

// *** tb/adc_conversion_control_test.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module adc_conversion_control_test;
  logic clk, rst, rd, wr, ack, wreq, icon, rpin, rbg, roe, pwr, cres, smp_o, stp_o, done_o, irq, on, f;
  logic [5:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] ben;
  logic [11:0] level, core, r;
  logic [7:0] ana, pull, oe, chan;
  logic [2:0] isrc, gain;
  int num_errors, checked, seed, cnt, smp, stp, n, m;
  logic [31:0] rq[$];
  logic [31:0] exp_rd;
  int tq[$];
  adc_conversion_control i_dut (.i_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(ben),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_core_result(core), .i_irq_ack(ack),
    .o_pin_analog(ana), .o_pin_pullup(pull), .o_pin_output_enable(oe), .o_channel_connect(chan),
    .o_internal_source(isrc), .o_internal_connect(icon), .o_ref_from_pin(rpin), .o_ref_from_bandgap(rbg),
    .o_ref_gain(gain), .o_ref_output_enable(roe), .o_converter_power(pwr), .o_converter_reset(cres),
    .o_sampling(smp_o), .o_conv_step(stp_o), .o_conversion_done(done_o), .o_irq_request(irq));
  adc_core_model i_core (.i_clk(clk), .i_power(pwr), .i_hold(cres), .i_level(level), .o_result(core));
  always #2 clk = ~clk;

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic access(input logic [3:0] idx, input logic [7:0] d, input logic w, input logic [3:0] be);
    int k;
    k = 0;
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    ben <= be;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (k >= 50) begin
      num_errors++;
      end_of_test();
    end
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : access

  task automatic bw(input logic [3:0] idx, input logic [7:0] d);
    access(idx, d, 1'b1, 4'hF);
  endtask : bw

  task automatic br(input logic [3:0] idx, input logic [7:0] e);
    rq.push_back({24'h0, e});
    access(idx, 8'h00, 1'b0, 4'hF);
  endtask : br

  // Read answers checked against the oldest note
  always @(posedge clk) begin
    if (rd === 1'b1 && wreq === 1'b0 && rq.size() > 0) begin
      exp_rd = rq.pop_front();
      `CHK("readdata", exp_rd, rdata)
    end
  end

  // Conversion timing measured from the first sampling cycle to the done pulse
  always @(posedge clk) begin
    if (on) begin
      cnt++;
      smp += (smp_o === 1'b1);
      stp += (stp_o === 1'b1);
    end
    if (smp_o === 1'b1 && !on) begin
      on = 1'b1;
      cnt = 0;
      smp = 1;
      stp = 0;
    end
    if (on && done_o === 1'b1 && tq.size() > 0) begin
      m = tq.pop_front();
      `CHK("cycles", 16 * m, cnt)
      `CHK("sample", 4 * m, smp)
      `CHK("steps", 12, stp)
      on = 1'b0;
    end
  end

  initial begin
    clk = 0; rst = 1; rd = 0; wr = 0; ack = 0; addr = 0; wdata = 0; ben = 4'hF; level = 0; on = 0;
    seed = 32'h356a;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) br(i[3:0], (i == 4) ? 8'hFF : 8'h00);
    br(4'hF, 8'h00);
    access(4'h5, 8'hFF, 1'b1, 4'h0);
    br(4'h5, 8'h00);
    bw(4'h1, 8'hFF);
    br(4'h1, 8'hE7);
    bw(4'h1, 8'h00);
    bw(4'h3, 8'h01);
    bw(4'h5, 8'hFF);
    bw(4'h4, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("analog", 8'h01, ana)
    `CHK("pullup", 8'hFE, pull)
    `CHK("drive", 8'hFE, oe)
    bw(4'h0, 8'h20);
    repeat (2) @(posedge clk);
    `CHK("power", 1'b1, pwr)
    `CHK("channel", 8'h01, chan)
    for (int c = 0; c < 16; c++) begin
      bw(4'h2, 8'h10 | c[7:0]);
      repeat (2) @(posedge clk);
      `CHK("refpin", (c >= 1 && c <= 4), rpin)
      `CHK("refbg", (c >= 10 && c <= 12), rbg)
      `CHK("gain", ((c >= 1 && c <= 4) || (c >= 10 && c <= 12)) ? c[2:0] : 3'h1, gain)
      `CHK("refout", 1'b1, roe)
    end
    for (int d = 0; d < 8; d++) begin
      f = d[1];
      r = $random(seed);
      level <= r;
      bw(4'h1, d[7:0]);
      bw(4'h8, d[0] ? 8'h03 : 8'h00);
      bw(4'h0, {3'b101, f, 4'h0});
      repeat (2) @(posedge clk);
      `CHK("convreset", 1'b1, cres)
      tq.push_back(1 << d);
      bw(4'h0, {3'b001, f, 4'h0});
      br(4'h0, {3'b011, f, 4'h0});
      n = 0;
      while (done_o !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 3000) begin
        num_errors++;
        end_of_test();
      end
      repeat (2) @(posedge clk);
      br(4'h0, {3'b001, f, 4'h0});
      br(4'h6, f ? {4'h0, r[11:8]} : r[11:4]);
      br(4'h7, f ? r[7:0] : {r[3:0], 4'h0});
      br(4'h8, d[0] ? 8'h07 : 8'h04);
      `CHK("irq", d[0], irq)
      if (d[0]) begin
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("irqclr", 1'b0, irq)
        br(4'h8, 8'h03);
      end else begin
        bw(4'h8, 8'h00);
        br(4'h8, 8'h00);
      end
    end
    bw(4'h0, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("offreset", 1'b1, cres)
    `CHK("offchan", 8'h00, chan)
    bw(4'h0, 8'h20);
    bw(4'h1, 8'h60);
    repeat (2) @(posedge clk);
    `CHK("intcon", 1'b1, icon)
    `CHK("intsrc", 3'h3, isrc)
    `CHK("extoff", 8'h00, chan)
    br(4'h7, {r[3:0], 4'h0});
    end_of_test();
  end
endmodule : adc_conversion_control_test

// *** tb/adc_core_model.sv ***
`timescale 1ns/1ns
// Analog converter core: presents the held input level while powered and out of reset
module adc_core_model (
  input wire logic i_clk,
  input wire logic i_power,
  input wire logic i_hold,
  input wire logic [11:0] i_level,
  output logic [11:0] o_result
);
  initial o_result = 12'h000;
  // Unpowered or held core gives a pattern that changes every cycle
  always @(posedge i_clk) begin
    if (i_power === 1'b1 && i_hold === 1'b0) begin
      o_result <= i_level;
    end else begin
      o_result <= ~o_result;
    end
  end
endmodule : adc_core_model
